// ---- nvpe_ctrl.sv ----
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
module nvpe_ctrl (
   input  wire logic                  SYS_CLK,
   input  wire logic                  RST,
   input  wire logic                  CE,
   input  wire logic                  PSEL,
   input  wire logic                  PENABLE,
   input  wire logic                  PWRITE,
   input  wire logic [7:0]            PADDR,
   input  wire logic [31:0]           PWDATA,
   input  wire logic [3:0]            PSTRB,
   output      logic [31:0]           PRDATA,
   output      logic                  PREADY,
   output      logic                  PSLVERR,
   input  wire nvpe_pkg::nvpe_flags_t  FLAGS,
   input  wire nvpe_pkg::nvpe_keys_t   KEYS,
   input  wire nvpe_pkg::nvpe_option_t OPTION,
   output      nvpe_pkg::nvpe_cmd_t    CMD,
   output      logic [31:0]           TARGET,
   output      logic                  IRQ
);
   import nvpe_pkg::*;

   logic [31:0] control;
   logic [31:0] target;
   logic [31:0] option_view;
   logic        lock_frozen;
   logic        busy_prev;
   logic        ready;
   logic [31:0] rdata;
   logic        slverr;
   logic        irq;

   wire access     = PSEL & PENABLE;
   wire commit     = access & ready;
   wire hit_ctrl   = (PADDR == NVPE_ADDR_CONTROL);
   wire hit_target = (PADDR == NVPE_ADDR_TARGET);
   wire hit_option = (PADDR == NVPE_ADDR_OPTION);
   wire mapped     = hit_ctrl | hit_target | hit_option;
   wire full_word  = (PSTRB == 4'hF);
   wire wr_commit  = commit & PWRITE & full_word;
   wire wr_ctrl    = wr_commit & hit_ctrl;
   wire wr_target  = wr_commit & hit_target;

   wire is_locked  = control[NVPE_BIT_LOCK];
   wire busy_rise  = FLAGS.busy & ~busy_prev;

   // Narrow writes are refused: every field is word-wide in meaning
   wire bad_write  = PWRITE & ~full_word;

   // Read mux; reserved bits of every register read as zero
   wire [31:0] read_mux = hit_ctrl   ? control :
                          hit_target ? target :
                          hit_option ? option_view : 32'h00000000;

   // Control register next value
   logic [31:0] next_control;
   wire sw_ctrl_ok = wr_ctrl & ~is_locked;
   wire [31:0] plain_next = sw_ctrl_ok
                          ? (PWDATA & NVPE_CONTROL_PLAIN_MASK)
                          : (control & NVPE_CONTROL_PLAIN_MASK);

   // Lock: a written 1 relocks; hardware unlock only while not frozen
   wire lock_set   = wr_ctrl & PWDATA[NVPE_BIT_LOCK];
   wire lock_clr   = KEYS.unlock_good & ~lock_frozen & ~lock_set;
   wire next_lock  = lock_set | (is_locked & ~lock_clr);

   // Permit: key sets, software clears by writing 0, set wins
   wire permit_set = KEYS.option_key_good;
   wire permit_clr = sw_ctrl_ok & ~PWDATA[NVPE_BIT_OPT_PERMIT];
   wire next_permit = permit_set | (control[NVPE_BIT_OPT_PERMIT] & ~permit_clr);

   // Start: software only sets; cleared once busy rises
   wire start_set  = sw_ctrl_ok & PWDATA[NVPE_BIT_START] & ~FLAGS.busy;
   wire next_start = start_set | (control[NVPE_BIT_START] & ~busy_rise);

   always_comb begin
      next_control = plain_next;
      next_control[NVPE_BIT_LOCK] = next_lock;
      next_control[NVPE_BIT_OPT_PERMIT] = next_permit;
      next_control[NVPE_BIT_START] = next_start;
   end

   // Interrupt sources, each gated by its own enable
   wire irq_ecc    = FLAGS.ecc_fault_flag & control[NVPE_BIT_ECC_IE];
   wire irq_done   = FLAGS.done_flag & control[NVPE_BIT_DONE_IE];
   wire irq_verify = (FLAGS.erase_check_fault | FLAGS.write_check_fault)
                   & control[NVPE_BIT_VERIFY_IE];
   wire irq_prog   = (FLAGS.not_blank_fault | FLAGS.protect_violation_flag)
                   & control[NVPE_BIT_PROG_IE];
   wire next_irq   = irq_ecc | irq_done | irq_verify | irq_prog;

   // Option view taken from the option bytes every cycle that CE is high
   logic [31:0] next_option;
   always_comb begin
      next_option = 32'h00000000;
      next_option[NVPE_BIT_BOOT_A] = OPTION.boot_select_a;
      next_option[NVPE_BIT_BOOT_OVR] = OPTION.boot_source_override;
      next_option[NVPE_BIT_BOOT_B] = OPTION.boot_select_b;
      next_option[NVPE_BIT_BOR_LO +: 3] = OPTION.brownout_level_code;
   end

   // Target address; held while an operation runs
   wire [31:0] next_target = (wr_target & ~FLAGS.busy) ? PWDATA : target;

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         control <= NVPE_CONTROL_RESET;
         target <= NVPE_TARGET_RESET;
         option_view <= NVPE_OPTION_RESET;
         lock_frozen <= 1'b0;
         busy_prev <= 1'b0;
         irq <= 1'b0;
      end else if (CE) begin
         control <= next_control;
         target <= next_target;
         option_view <= next_option;
         lock_frozen <= lock_frozen | (KEYS.unlock_bad & is_locked);
         busy_prev <= FLAGS.busy;
         irq <= next_irq;
      end
   end

   // APB: one wait state, answer registered so outputs come from flops
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         ready <= 1'b0;
         rdata <= 32'h00000000;
         slverr <= 1'b0;
      end else if (CE) begin
         ready <= access & ~ready;
         rdata <= (access & ~ready & ~PWRITE) ? read_mux : 32'h00000000;
         slverr <= access & ~ready & (~mapped | bad_write);
      end
   end

   assign PREADY  = ready;
   assign PRDATA  = rdata;
   assign PSLVERR = slverr;
   assign IRQ     = irq;
   assign TARGET  = target;

   // Mode bits straight from the control flops
   assign CMD.start                  = control[NVPE_BIT_START];
   assign CMD.program_check_select   = control[NVPE_BIT_CHECK_SEL];
   // Sequencer must qualify option modes with this bit; no gating here
   assign CMD.option_write_permit    = control[NVPE_BIT_OPT_PERMIT];
   assign CMD.option_area_erase_mode = control[NVPE_BIT_OPT_ERASE];
   assign CMD.option_area_write_mode = control[NVPE_BIT_OPT_WRITE];
   assign CMD.whole_array_erase      = control[NVPE_BIT_WHOLE_ERASE];
   assign CMD.page_erase_mode        = control[NVPE_BIT_PAGE_ERASE];
   assign CMD.array_write_mode       = control[NVPE_BIT_ARRAY_WRITE];
   assign CMD.locked                 = control[NVPE_BIT_LOCK];

endmodule

// ---- nvpe_ctrl_asserts.sv ----
`timescale 1ns/1ps
module nvpe_ctrl_asserts
   import nvpe_pkg::*;
(
   input wire logic        SYS_CLK,
   input wire logic        RST,
   input wire logic        CE,
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [7:0]  PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic        PREADY,
   input wire nvpe_flags_t FLAGS,
   input wire nvpe_keys_t  KEYS,
   input wire nvpe_cmd_t   CMD,
   input wire logic [31:0] TARGET,
   input wire logic        IRQ
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (RST);
   logic bad_seen;
   wire  commit = PSEL && PENABLE && PREADY && PWRITE;
   wire  relock = commit && PADDR == 8'h10 && PWDATA[7];
   wire  wr_tgt = commit && PADDR == 8'h14;
   // Sticky until reset, like the lock pinning it mirrors
   always_ff @(posedge SYS_CLK) begin
      if (RST)
         bad_seen <= 1'b0;
      else if (CE && KEYS.unlock_bad && CMD.locked)
         bad_seen <= 1'b1;
   end
   chk_irq_quiet: assert property (CE && FLAGS[6:1] == 6'h00 |=> !IRQ)
      else $error("irq with no flag set");
   chk_lock_hold: assert property (CMD.locked && !KEYS.unlock_good |=> CMD.locked)
      else $error("lock dropped without key");
   chk_unlock_key: assert property (CE && KEYS.unlock_good && CMD.locked && !bad_seen && !KEYS.unlock_bad
      && !relock |=> !CMD.locked)
      else $error("good key did not unlock");
   chk_lock_pinned: assert property (bad_seen |-> CMD.locked)
      else $error("lock changed after failed unlock");
   chk_permit_key: assert property (CE && KEYS.option_key_good |=> CMD.option_write_permit)
      else $error("option key did not set permit");
   chk_start_clear: assert property (CE && $rose(FLAGS.busy) |=> !CMD.start)
      else $error("start not cleared by busy");
   chk_start_locked: assert property (CMD.locked && !CMD.start |=> !CMD.start)
      else $error("start set while locked");
   chk_target_busy: assert property (FLAGS.busy && wr_tgt |=> $stable(TARGET))
      else $error("target written while busy");
   cover property (KEYS.unlock_good && CMD.locked);
   cover property ($rose(FLAGS.busy) && CMD.start);
   cover property ($rose(IRQ));
endmodule
bind nvpe_ctrl nvpe_ctrl_asserts u_chk (.SYS_CLK(SYS_CLK), .RST(RST), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
   .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .FLAGS(FLAGS), .KEYS(KEYS),
   .CMD(CMD), .TARGET(TARGET), .IRQ(IRQ));

// ---- nvpe_pkg.sv ----
package nvpe_pkg;

   localparam logic [7:0]  NVPE_ADDR_CONTROL = 8'h10;
   localparam logic [7:0]  NVPE_ADDR_TARGET  = 8'h14;
   localparam logic [7:0]  NVPE_ADDR_OPTION  = 8'h18;

   localparam logic [31:0] NVPE_CONTROL_RESET = 32'h00000080;
   localparam logic [31:0] NVPE_TARGET_RESET  = 32'h00000000;
   localparam logic [31:0] NVPE_OPTION_RESET  = 32'h0C800000;

   localparam int NVPE_BIT_ECC_IE    = 13;
   localparam int NVPE_BIT_DONE_IE   = 12;
   localparam int NVPE_BIT_VERIFY_IE = 11;
   localparam int NVPE_BIT_PROG_IE   = 10;
   localparam int NVPE_BIT_OPT_PERMIT = 9;
   localparam int NVPE_BIT_CHECK_SEL = 8;
   localparam int NVPE_BIT_LOCK      = 7;
   localparam int NVPE_BIT_START     = 6;
   localparam int NVPE_BIT_OPT_ERASE = 5;
   localparam int NVPE_BIT_OPT_WRITE = 4;
   localparam int NVPE_BIT_WHOLE_ERASE = 2;
   localparam int NVPE_BIT_PAGE_ERASE = 1;
   localparam int NVPE_BIT_ARRAY_WRITE = 0;

   localparam int NVPE_BIT_BOOT_A    = 27;
   localparam int NVPE_BIT_BOOT_OVR  = 26;
   localparam int NVPE_BIT_BOOT_B    = 23;
   localparam int NVPE_BIT_BOR_LO    = 8;

   // Plain software-writable bits; lock, permit and start have their own paths
   localparam logic [31:0] NVPE_CONTROL_PLAIN_MASK = 32'h00003D37;

   typedef struct packed {
      logic ecc_fault_flag;
      logic erase_check_fault;
      logic done_flag;
      logic protect_violation_flag;
      logic write_check_fault;
      logic not_blank_fault;
      logic busy;
   } nvpe_flags_t;

   typedef struct packed {
      logic       boot_select_a;
      logic       boot_source_override;
      logic       boot_select_b;
      logic [2:0] brownout_level_code;
   } nvpe_option_t;

   typedef struct packed {
      logic start;
      logic program_check_select;
      logic option_write_permit;
      logic option_area_erase_mode;
      logic option_area_write_mode;
      logic whole_array_erase;
      logic page_erase_mode;
      logic array_write_mode;
      logic locked;
   } nvpe_cmd_t;

   typedef struct packed {
      logic unlock_good;
      logic unlock_bad;
      logic option_key_good;
   } nvpe_keys_t;

endpackage

// ---- tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
   import nvpe_pkg::*;
   logic         clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, pready, pslverr, irq, er;
   logic         ce = 1'b1;
   logic [7:0]   paddr = 8'h00;
   logic [3:0]   pstrb = 4'hF;
   logic [31:0]  pwdata = 32'h0, prdata, target, rd;
   nvpe_flags_t  flags = '0;
   nvpe_keys_t   keys = '0;
   nvpe_option_t opt = 6'h38;
   nvpe_cmd_t    cmd;
   int           miscompares = 0, cmp_count = 0;
   int           ie_bit[7] = '{0, 10, 11, 10, 12, 11, 13};
   always #5 clk = ~clk;
   nvpe_ctrl uut (.SYS_CLK(clk), .RST(rst), .CE(ce), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
      .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .FLAGS(flags), .KEYS(keys), .OPTION(opt), .CMD(cmd), .TARGET(target), .IRQ(irq));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Waits for pready, only the watchdog ends a hang; read data and error taken at that edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge clk);
      {psel, pwr, paddr, pwdata, pstrb} <= {1'b1, w, a, d, s};
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      {psel, pen} <= 2'b00;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
      apb(1'b1, a, d, 4'hF);
      chk(32'(er), 32'(e));
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0, 4'hF);
      chk(rd, x);
   endtask
   task automatic pulse(input nvpe_keys_t k);
      @(posedge clk);
      keys <= k;
      @(posedge clk);
      keys <= '0;
   endtask
   task automatic test_done;
      $display("miscompares %0d cmp_count %0d", miscompares, cmp_count);
      if (miscompares == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      rdc(8'h10, 32'h00000080);
      rdc(8'h18, 32'h0C800000);
      opt <= 6'h1C;
      wr(8'h18, 32'hFFFFFFFF, 1'b0);
      rdc(8'h18, 32'h04800400);
      wr(8'h1C, 32'h00000001, 1'b1);
      rdc(8'h1C, 32'h00000000);
      wr(8'h10, 32'h00003F7F, 1'b0);
      rdc(8'h10, 32'h00000080);
      pulse(3'b100);
      rdc(8'h10, 32'h00000000);
      wr(8'h10, 32'h00003D37, 1'b0);
      apb(1'b1, 8'h10, 32'h00000000, 4'h3);
      chk(32'(er), 32'h00000001);
      rdc(8'h10, 32'h00003D37);
      chk(32'(cmd), 32'h000000BE);
      for (int j = 1; j < 7; j++) begin
         wr(8'h10, 32'h00003C00 ^ (32'h1 << ie_bit[j]), 1'b0);
         flags <= nvpe_flags_t'(7'h01 << j);
         repeat (3) @(posedge clk);
         chk(32'(irq), 32'h00000000);
         wr(8'h10, 32'h1 << ie_bit[j], 1'b0);
         repeat (2) @(posedge clk);
         chk(32'(irq), 32'h00000001);
         flags <= '0;
      end
      pulse(3'b001);
      rdc(8'h10, 32'h00002200);
      wr(8'h10, 32'h00000041, 1'b0);
      rdc(8'h10, 32'h00000041);
      flags <= 7'h01;
      repeat (2) @(posedge clk);
      rdc(8'h10, 32'h00000001);
      wr(8'h14, 32'h00001234, 1'b0);
      rdc(8'h14, 32'h00000000);
      flags <= '0;
      wr(8'h14, 32'hA5A50004, 1'b0);
      @(posedge clk);
      chk(target, 32'hA5A50004);
      wr(8'h10, 32'h00000080, 1'b0);
      pulse(3'b010);
      pulse(3'b100);
      rdc(8'h10, 32'h00000080);
      // Mid-run reset must unpin the lock so the good key releases it again
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rdc(8'h14, 32'h00000000);
      pulse(3'b100);
      rdc(8'h10, 32'h00000000);
      // Clock enable low must freeze the permit flop against a key pulse
      ce <= 1'b0;
      pulse(3'b001);
      ce <= 1'b1;
      rdc(8'h10, 32'h00000000);
      test_done;
   end
   initial begin
      #100000;
      miscompares++;
      test_done;
   end
endmodule
